// file: sdes_pkg.sv
package sdes_pkg;

	// register indices; byte address is four times the index
	localparam logic [15:0] SDES_IDX_MASK      = 16'h1C20;
	localparam logic [15:0] SDES_IDX_PENDING   = 16'h1C21;
	localparam int          SDES_ADR_W         = 16;
	localparam int          SDES_DAT_W         = 32;

	// pending register layout
	localparam int          SDES_A_VALID_BIT   = 0;
	localparam int          SDES_A_PORT_LSB    = 1;
	localparam int          SDES_A_REASON_LSB  = 3;
	localparam int          SDES_B_VALID_BIT   = 7;
	localparam int          SDES_B_PORT_LSB    = 8;
	localparam int          SDES_B_REASON_LSB  = 10;
	localparam int          SDES_REASON_W      = 4;
	localparam int          SDES_PORT_W        = 2;

	// mask register layout and reset
	localparam int          SDES_MASK_BIT      = 0;
	localparam logic        SDES_MASK_RESET    = 1'b1;

	// reset values of the capture fields
	localparam logic [3:0]  SDES_REASON_RESET  = 4'h0;
	localparam logic [1:0]  SDES_PORT_RESET    = 2'h0;

	// drop reason codes
	localparam logic [3:0]  SDES_RSN_BCAST_LVL = 4'h0;
	localparam logic [3:0]  SDES_RSN_RED       = 4'h1;
	localparam logic [3:0]  SDES_RSN_NO_BUF    = 4'h2;
	localparam logic [3:0]  SDES_RSN_NO_DESC   = 4'h3;
	localparam logic [3:0]  SDES_RSN_NO_DEST   = 4'h4;
	localparam logic [3:0]  SDES_RSN_RX_ERR    = 4'h5;
	localparam logic [3:0]  SDES_RSN_BUF_LVL   = 4'h6;
	localparam logic [3:0]  SDES_RSN_YELLOW    = 4'h9;

	// receive-error drops count only above this length in bytes
	localparam int          SDES_LEN_W         = 12;
	localparam logic [11:0] SDES_RX_ERR_MIN    = 12'h040;

	// source port codes
	localparam logic [1:0]  SDES_PORT_HOST     = 2'h0;
	localparam logic [1:0]  SDES_PORT_1        = 2'h1;
	localparam logic [1:0]  SDES_PORT_2        = 2'h2;

	// conditions reported by the drop logic with its drop strobe
	typedef struct packed {
		logic        lookup_miss;
		logic        bcast_level_over;
		logic        no_dest_port;
		logic        red_drop_en;
		logic        colored_red;
		logic        yellow_drop_en;
		logic        colored_yellow;
		logic        random_pick;
		logic        no_buffer;
		logic        no_descriptor;
		logic        rx_error;
		logic [11:0] pkt_len;
		logic        buf_level_over;
		logic [1:0]  src_port;
	} sdes_drop_t;

	// one captured record
	typedef struct packed {
		logic       valid;
		logic [3:0] reason;
		logic [1:0] port;
	} sdes_rec_t;

	localparam sdes_rec_t SDES_REC_RESET = '{valid: 1'b0, reason: SDES_REASON_RESET, port: SDES_PORT_RESET};

endpackage

// file: sdes_reason_enc.sv
`timescale 1ns/10ps
module sdes_reason_enc
	import sdes_pkg::*;
(
	input  wire logic       drop_i,
	input  sdes_drop_t      cause_i,
	output logic            rec_valid_o,
	output sdes_rec_t       rec_o
);

	logic [3:0] code;
	logic       known;

	// first listed cause wins when several hold at once
	always_comb begin
		code  = SDES_RSN_BUF_LVL;
		known = 1'b1;
		if (cause_i.no_buffer) begin
			code = SDES_RSN_NO_BUF;
		end else if (cause_i.no_descriptor) begin
			code = SDES_RSN_NO_DESC;
		end else if (cause_i.rx_error && (cause_i.pkt_len > SDES_RX_ERR_MIN)) begin
			code = SDES_RSN_RX_ERR;
		end else if (cause_i.lookup_miss && cause_i.bcast_level_over) begin
			code = SDES_RSN_BCAST_LVL;
		end else if (cause_i.lookup_miss && cause_i.no_dest_port) begin
			code = SDES_RSN_NO_DEST;
		end else if (cause_i.red_drop_en && cause_i.colored_red) begin
			code = SDES_RSN_RED;
		end else if (cause_i.yellow_drop_en && cause_i.colored_yellow && cause_i.random_pick) begin
			code = SDES_RSN_YELLOW;
		end else if (cause_i.buf_level_over) begin
			code = SDES_RSN_BUF_LVL;
		end else begin
			// reserved codes are never produced; unexplained drops are not recorded
			known = 1'b0;
		end
	end

	assign rec_valid_o  = drop_i && known;
	assign rec_o        = '{valid: 1'b1, reason: code, port: cause_i.src_port};

endmodule

// file: sdes_drop_status.sv
// The Wishbone slave port was decided locally.
`timescale 1ns/10ps
module sdes_drop_status
	import sdes_pkg::*;
(
	input  wire logic                    clk_i,
	input  wire logic                    rst_i,
	input  wire logic                    cyc_i,
	input  wire logic                    stb_i,
	input  wire logic                    we_i,
	input  wire logic [SDES_ADR_W-1:0]   adr_i,
	input  wire logic [3:0]              sel_i,
	input  wire logic [SDES_DAT_W-1:0]   dat_i,
	output logic      [SDES_DAT_W-1:0]   dat_o,
	output logic                         ack_o,
	input  wire logic                    drop_i,
	input  sdes_drop_t                   drop_cause_i,
	output logic                         irq_o
);

	logic                  ack_reg,  ack_next;
	logic [SDES_DAT_W-1:0] dat_reg,  dat_next;
	logic                  mask_reg, mask_next;
	sdes_rec_t             a_reg,    a_next;
	sdes_rec_t             b_reg,    b_next;

	logic                  new_valid;
	sdes_rec_t             new_rec;
	logic                  take;
	logic                  hit_mask;
	logic                  hit_pend;
	logic                  rd_clear;
	sdes_rec_t             a_kept;
	sdes_rec_t             b_kept;

	function automatic logic idx_hit(input logic [SDES_ADR_W-1:0] adr, input logic [15:0] idx);
		logic [17:0] byte_adr;
		byte_adr = {idx, 2'b00};
		return adr == byte_adr[SDES_ADR_W-1:0];
	endfunction

	function automatic logic [SDES_DAT_W-1:0] pend_word(input sdes_rec_t a, input sdes_rec_t b);
		logic [SDES_DAT_W-1:0] w;
		w = '0;
		w[SDES_A_VALID_BIT]                                = a.valid;
		w[SDES_A_PORT_LSB   +: SDES_PORT_W]               = a.port;
		w[SDES_A_REASON_LSB +: SDES_REASON_W]             = a.reason;
		w[SDES_B_VALID_BIT]                                = b.valid;
		w[SDES_B_PORT_LSB   +: SDES_PORT_W]               = b.port;
		w[SDES_B_REASON_LSB +: SDES_REASON_W]             = b.reason;
		return w;
	endfunction

	sdes_reason_enc u_enc (
		.drop_i      (drop_i),
		.cause_i     (drop_cause_i),
		.rec_valid_o (new_valid),
		.rec_o       (new_rec)
	);

	assign take     = cyc_i && stb_i && !ack_reg;
	assign hit_mask = idx_hit(adr_i, SDES_IDX_MASK);
	assign hit_pend = idx_hit(adr_i, SDES_IDX_PENDING);
	assign rd_clear = take && !we_i && hit_pend;

	// bus slave: one wait state, unmapped reads give zero, unmapped writes ignored
	always_comb begin
		ack_next  = take;
		dat_next  = dat_reg;
		mask_next = mask_reg;
		if (take) begin
			dat_next = '0;
			if (!we_i && hit_pend) begin
				dat_next = pend_word(a_reg, b_reg);
			end else if (!we_i && hit_mask) begin
				dat_next[SDES_MASK_BIT] = mask_reg;
			end
			if (we_i && hit_mask && sel_i[0]) begin
				mask_next = dat_i[SDES_MASK_BIT];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg  <= 1'b0;
			dat_reg  <= '0;
			mask_reg <= SDES_MASK_RESET;
		end else begin
			ack_reg  <= ack_next;
			dat_reg  <= dat_next;
			mask_reg <= mask_next;
		end
	end

	// snapshot goes out with the ack, so the clear loses nothing already read
	always_comb begin
		a_kept = rd_clear ? SDES_REC_RESET : a_reg;
		b_kept = rd_clear ? SDES_REC_RESET : b_reg;
		a_next = a_kept;
		b_next = b_kept;
		// fill A first, then B
		// a drop in the clearing cycle still lands: set wins over clear
		if (new_valid) begin
			if (!a_kept.valid) begin
				a_next = new_rec;
			end else if (!b_kept.valid) begin
				b_next = new_rec;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			a_reg <= SDES_REC_RESET;
			b_reg <= SDES_REC_RESET;
		end else begin
			a_reg <= a_next;
			b_reg <= b_next;
		end
	end

	assign ack_o = ack_reg;
	assign dat_o = dat_reg;

	// status left as is when masked
	assign irq_o = (a_reg.valid || b_reg.valid) && !mask_reg;

endmodule

// file: sdes_drop_status_sva.sv
`timescale 1ns/10ps
module sdes_sva_chk
	import sdes_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        we_i,
	input wire logic [15:0] adr_i,
	input wire logic [3:0]  sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic        ack_o,
	input wire logic        drop_i,
	input sdes_drop_t       drop_cause_i,
	input wire logic        irq_o
);
	logic mask_reg;
	wire  take = cyc_i && stb_i && !ack_o;
	// shadow of the mask, updated on the taking edge
	always_ff @(posedge clk_i)
		if (rst_i)
			mask_reg <= 1'b1;
		else if (take && we_i && adr_i == 16'h7080 && sel_i[0])
			mask_reg <= dat_i[0];
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_rd;
		take && !we_i && adr_i == 16'h7084 ##1 ack_o;
	endsequence
	a_ack_pulse:
		assert property (ack_o |=> !ack_o) else $error("ack too long");
	a_ack_answer:
		assert property (take |=> ack_o) else $error("no ack");
	a_mask_blocks:
		assert property (mask_reg |-> !irq_o) else $error("irq masked");
	a_drop_raises:
		assert property (drop_i && drop_cause_i.no_buffer && !mask_reg && !cyc_i |=> irq_o) else $error("no irq");
	a_read_clears:
		assert property (take && !we_i && adr_i == 16'h7084 && !drop_i |=> !irq_o) else $error("not cleared");
	a_rsvd_zero:
		assert property (s_rd |-> dat_o[31:14] == 18'h0) else $error("reserved set");
	a_b_after_a:
		assert property (s_rd |-> !dat_o[7] || dat_o[0]) else $error("B before A");
	a_code_legal:
		assert property (s_rd |-> !dat_o[0] || dat_o[6:3] inside {[4'h0:4'h6], 4'h9}) else $error("bad code");
endmodule
bind sdes_drop_status sdes_sva_chk u_chk (
	.clk_i        (clk_i),
	.rst_i        (rst_i),
	.cyc_i        (cyc_i),
	.stb_i        (stb_i),
	.we_i         (we_i),
	.adr_i        (adr_i),
	.sel_i        (sel_i),
	.dat_i        (dat_i),
	.dat_o        (dat_o),
	.ack_o        (ack_o),
	.drop_i       (drop_i),
	.drop_cause_i (drop_cause_i),
	.irq_o        (irq_o)
);

// file: tb.sv
`timescale 1ns/10ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin errors++; $display("wrong value t=%0t %h %h", $time, a, b); end end
module tb
	import sdes_pkg::*;
;
	logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, drop_i = 1'b0;
	logic [15:0] adr_i = 16'h0000;
	logic [3:0]  sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0, dat_o, q;
	logic        ack_o, irq_o;
	sdes_drop_t  drop_cause_i = '0;
	int          errors = 0, samples_checked = 0;
	logic [3:0]  codes [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9};
	always #10 clk_i = ~clk_i;
	sdes_drop_status u_sdes_drop_status (
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.cyc_i        (cyc_i),
		.stb_i        (stb_i),
		.we_i         (we_i),
		.adr_i        (adr_i),
		.sel_i        (sel_i),
		.dat_i        (dat_i),
		.dat_o        (dat_o),
		.ack_o        (ack_o),
		.drop_i       (drop_i),
		.drop_cause_i (drop_cause_i),
		.irq_o        (irq_o)
	);
	// 4'hF: receive error at exactly 64 bytes, must be dropped silently
	function automatic sdes_drop_t mk(input logic [3:0] c, input logic [1:0] p);
		case (c)
			4'h0: return {11'b11000000000, 12'h000, 1'b0, p};
			4'h1: return {11'b00011000000, 12'h000, 1'b0, p};
			4'h2: return {11'b00000000100, 12'h000, 1'b0, p};
			4'h3: return {11'b00000000010, 12'h000, 1'b0, p};
			4'h4: return {11'b10100000000, 12'h000, 1'b0, p};
			4'h5: return {11'b00000000001, 12'h041, 1'b0, p};
			4'h6: return {11'b00000000000, 12'h000, 1'b1, p};
			4'h9: return {11'b00000111000, 12'h000, 1'b0, p};
			default: return {11'b00000000001, 12'h040, 1'b0, p};
		endcase
	endfunction
	function automatic logic [31:0] ex(input logic [3:0] ra, input logic [1:0] pa, input logic [3:0] rb,
		input logic [1:0] pb, input logic vb);
		return {18'h0, rb, pb, vb, ra, pa, 1'b1};
	endfunction
	task automatic report_and_stop;
		if (errors == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// no wait limit here: the watchdog ends a hung access
	task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
		@(posedge clk_i);
		{cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, s, d};
		do
			@(posedge clk_i);
		while (ack_o !== 1'b1);
		q = dat_o;
		{cyc_i, stb_i} <= 2'b00;
	endtask
	task automatic rd(input logic [15:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		`CHK(q, e)
	endtask
	// back-to-back drops, one per cycle
	task automatic drops(input logic [3:0] c, input logic [1:0] p, input int n);
		for (int j = 0; j < n; j++) begin
			@(posedge clk_i);
			drop_i <= 1'b1;
			drop_cause_i <= mk(c + 4'(j), p + 2'(j));
		end
		@(posedge clk_i);
		drop_i <= 1'b0;
		@(posedge clk_i);
	endtask
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(16'h7080, 32'h1);
		rd(16'h7084, 32'h0);
		rd(16'h7000, 32'h0);
		wb(1'b1, 16'h7084, 32'h3FFF);
		rd(16'h7084, 32'h0);
		wb(1'b1, 16'h7080, 32'h0);
		rd(16'h7080, 32'h0);
		for (int i = 0; i < 8; i++) begin
			drops(codes[i], 2'(i % 3), 1);
			`CHK(irq_o, 1'b1)
			rd(16'h7084, ex(codes[i], 2'(i % 3), 4'h0, 2'h0, 1'b0));
			`CHK(irq_o, 1'b0)
		end
		drops(4'hF, 2'h1, 1);
		rd(16'h7084, 32'h0);
		drops(4'h1, 2'h0, 3);
		rd(16'h7084, ex(4'h1, 2'h0, 4'h2, 2'h1, 1'b1));
		rd(16'h7084, 32'h0);
		wb(1'b1, 16'h7080, 32'h1);
		drops(4'h2, 2'h2, 1);
		`CHK(irq_o, 1'b0)
		rd(16'h7084, ex(4'h2, 2'h2, 4'h0, 2'h0, 1'b0));
		wb(1'b1, 16'h7080, 32'h0, 4'hE);
		rd(16'h7080, 32'h1);
		drops(4'h6, 2'h0, 1);
		// drop lands in the very edge that takes the clearing read
		fork
			rd(16'h7084, ex(4'h6, 2'h0, 4'h0, 2'h0, 1'b0));
			begin
				@(posedge clk_i);
				drop_i <= 1'b1;
				drop_cause_i <= mk(4'h3, 2'h1);
				@(posedge clk_i);
				drop_i <= 1'b0;
			end
		join
		rd(16'h7084, ex(4'h3, 2'h1, 4'h0, 2'h0, 1'b0));
		wb(1'b1, 16'h7080, 32'h0);
		drops(4'h9, 2'h2, 1);
		`CHK(irq_o, 1'b1)
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		`CHK(irq_o, 1'b0)
		rd(16'h7080, 32'h1);
		rd(16'h7084, 32'h0);
		report_and_stop;
	end
	initial begin
		#200us;
		errors++;
		report_and_stop;
	end
endmodule
